// ===== mbrsu_link_model.sv
// Purpose: remote station model on the master link
// Assumes: one answer for every transmitted request while silent is low
// Notes: the answer code starts at 0; the bench changes it only before launching requests 7 and 2041
`timescale 1ns/100ps
`default_nettype none
module mbrsu_link_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mtx_valid,
	input wire logic [4:0] code,
	input wire logic silent,
	output logic mrsp_valid,
	output logic [4:0] mrsp_code
);
	logic [3:0] cnt_q; // cycles left until the answer, 0 when idle
	// answer six cycles after each transmission unless silent is high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 4'h0;
			mrsp_valid <= 1'b0;
			mrsp_code <= 5'h00;
		end else begin
			mrsp_valid <= (cnt_q == 4'h1) && !silent;
			// outside the answer the code lines carry junk
			mrsp_code <= (cnt_q == 4'h1) ? code : ~code;
			cnt_q <= mtx_valid ? 4'h5 : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
		end
	end
endmodule
`default_nettype wire

// ===== mbrsu_ms_timer.sv
// Purpose: millisecond down-counter with a one-cycle done pulse
// Assumes: start is a one-cycle pulse, ms is at least 1
// Notes: a new start restarts the count
`timescale 1ns/100ps
`default_nettype none
module mbrsu_ms_timer #(
	parameter int unsigned CYC_PER_MS = mbrsu_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [12:0] ms,
	output logic done
);
	logic [16:0] pre_q, pre_d; // cycles within the current ms
	logic [12:0] cnt_q, cnt_d; // ms still to run
	logic done_d; // end of count

	// prescale and count down
	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (start) begin
			pre_d = 17'h00000;
			cnt_d = ms;
		end else if (cnt_q != 13'h0000) begin
			if (pre_q == 17'(CYC_PER_MS - 1)) begin
				pre_d = 17'h00000;
				cnt_d = cnt_q - 13'h0001;
				done_d = (cnt_q == 13'h0001);
			end else begin
				pre_d = pre_q + 17'h00001;
			end
		end
	end

	// register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= 17'h00000;
			cnt_q <= 13'h0000;
			done <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			done <= done_d;
		end
	end
endmodule
`default_nettype wire

// ===== mbrsu_pkg.sv
// Purpose: shared constants and carriers for the modbus request/status unit
// Assumes: 125 MHz core clock, 16-bit register port
// Notes: every offset, control field and timing figure of the unit lives here
package mbrsu_pkg;
	// clock and time base
	localparam int unsigned CLK_NS = 8; // clock period in ns
	localparam int unsigned T_MS_NS = 1000000; // one millisecond in ns
	localparam int unsigned CYC_PER_MS = T_MS_NS / CLK_NS; // cycles per ms
	localparam int unsigned CLK_HZ = 1000000000 / CLK_NS; // clock rate in Hz
	// millisecond limits for wait and response delay
	localparam logic [12:0] MS_MIN = 13'h0001; // 1 ms
	localparam logic [12:0] MS_MAX = 13'h1388; // 5000 ms
	localparam int unsigned RXTMO_UNIT_MS = 10; // receive timeout unit
	// serial character framing
	localparam int unsigned CHAR_BITS = 11; // start, 8 data, parity, stop
	localparam int unsigned GAP_CHAR_HALVES = 3; // 1.5 characters
	localparam int unsigned GAP_FRAME_HALVES = 7; // 3.5 characters
	// selectable baud rates, index 0 to 4
	localparam int unsigned BAUD0 = 9600;
	localparam int unsigned BAUD1 = 19200;
	localparam int unsigned BAUD2 = 38400;
	localparam int unsigned BAUD3 = 57600;
	localparam int unsigned BAUD4 = 115200;
	// request numbering
	localparam logic [10:0] REQ_MAX = 11'h7F8; // request 2040
	localparam logic [10:0] SHARED_IDX = 11'h000; // shared status word slot
	// error codes
	localparam logic [4:0] EC_OK = 5'h00;
	localparam logic [4:0] EC_FUNC = 5'h01;
	localparam logic [4:0] EC_ADDR = 5'h02;
	localparam logic [4:0] EC_QTY = 5'h03;
	localparam logic [4:0] EC_ASCII = 5'h11;
	localparam logic [4:0] EC_LEN = 5'h12;
	localparam logic [4:0] EC_BCC = 5'h13;
	localparam logic [4:0] EC_SLAVE = 5'h14;
	localparam logic [4:0] EC_TMO = 5'h16;
	// station limits
	localparam logic [7:0] STN_MAX_NEW = 8'hF7; // 247
	localparam logic [7:0] STN_MAX_OLD = 8'h1F; // 31
	// ascii framing characters
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	// register indices
	localparam logic [3:0] R_CTRL = 4'h0;
	localparam logic [3:0] R_STAT = 4'h1;
	localparam logic [3:0] R_RESULT = 4'h2;
	localparam logic [3:0] R_WAIT = 4'h3;
	localparam logic [3:0] R_LOG = 4'h4;
	localparam logic [3:0] R_LAUNCH = 4'h5;
	localparam logic [3:0] R_SLVSEL = 4'h6;
	localparam logic [3:0] R_RXTMO = 4'h7;
	localparam logic [3:0] R_STATION = 4'h8;
	localparam logic [3:0] R_RDLY = 4'h9;
	localparam logic [3:0] R_ERRIDX = 4'hA;
	localparam logic [3:0] R_ERRDAT = 4'hB;
	// control register fields and reset values
	localparam int unsigned CTRL_SHARED = 0;
	localparam int unsigned CTRL_ASCII = 1;
	localparam int unsigned CTRL_LEGACY = 2;
	localparam int unsigned CTRL_BAUD_LSB = 3;
	localparam int unsigned CTRL_RETRY_LSB = 8;
	localparam logic [15:0] CTRL_RST = 16'h0300; // three retries, 9600 rtu
	localparam logic [3:0] RETRY_MIN = 4'h1;
	localparam logic [3:0] RETRY_MAX = 4'hA;
	localparam logic [15:0] WAIT_RST = 16'h0001;
	localparam logic [7:0] RXTMO_RST = 8'h0A;
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [15:0] RDLY_RST = 16'h0001;
	// master request and slave access carriers
	typedef struct packed {
		logic [10:0] num;
		logic [7:0] slave;
	} mbrsu_req_t;
	typedef struct packed {
		logic [7:0] func;
		logic [15:0] addr;
	} mbrsu_acc_t;
endpackage

// ===== mbrsu_ram.sv
// Purpose: per-request error status words
// Assumes: one write port, one read port, synchronous read
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module mbrsu_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic [10:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [10:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:2047]; // one word per request slot

	// write and registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ===== mbrsu_tb_top.sv
// Purpose: self-checking bench for the modbus request/status unit
// Assumes: ten cycles per ms, slave frames sent in ascii
// Notes: the link model answers every transmission except while silent is held high
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module mbrsu_tb_top;
	logic clk = 1'b0; // core clock
	logic rst_b = 1'b0; // reset, active low
	logic scan_end = 1'b0; // end of scan marker
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] q; // last word read
	logic mtx_valid, mrsp_valid, slv_svc, slv_resp_start;
	logic rx_valid = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic [4:0] mrsp_code;
	logic [4:0] code = 5'h00; // answer code of the link model
	logic silent = 1'b0; // link model stays mute when high
	mbrsu_pkg::mbrsu_req_t mtx_req;
	mbrsu_pkg::mbrsu_acc_t slv_acc, acc;
	int num_errors = 0, checks_done = 0, n_tx = 0, n_svc = 0, n_rsp = 0, c, i;
	mbrsu_top #(.CYC_PER_MS(10)) dut_u (.clk(clk), .rst_b(rst_b), .scan_end(scan_end),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mtx_valid(mtx_valid), .mtx_req(mtx_req),
		.mrsp_valid(mrsp_valid), .mrsp_code(mrsp_code), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .slv_svc(slv_svc), .slv_acc(slv_acc),
		.slv_resp_start(slv_resp_start));
	mbrsu_link_model link_u (.clk(clk), .rst_b(rst_b), .mtx_valid(mtx_valid), .code(code),
		.silent(silent),
		.mrsp_valid(mrsp_valid), .mrsp_code(mrsp_code));
	// 8 ns clock
	initial begin
		forever #4 clk = ~clk;
	end
	// count output pulses
	always @(posedge clk) begin
		if (mtx_valid === 1'b1) n_tx <= n_tx + 1;
		if (slv_svc === 1'b1) n_svc <= n_svc + 1;
		if (slv_svc === 1'b1) acc <= slv_acc;
		if (slv_resp_start === 1'b1) n_rsp <= n_rsp + 1;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
		rd(a);
		`CHK(q & m, e)
	endtask
	task automatic scan;
		@(posedge clk);
		scan_end <= 1'b1;
		@(posedge clk);
		scan_end <= 1'b0;
	endtask
	task automatic send(input string s);
		for (int k = 0; k < s.len(); k++) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_byte <= s[k];
			@(posedge clk);
			rx_valid <= 1'b0;
		end
	endtask
	// cycles until the next transmission, 200 if none
	task automatic wait_tx(output int n);
		int n0;
		n0 = n_tx;
		n = 0;
		while (n_tx == n0 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#(8 * 40000);
		num_errors++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdc(4'h1, 16'h0008, 16'h0008);
		i = 0;
		while (q[3] !== 1'b0 && i < 3000) begin
			rd(4'h1);
			i++;
		end
		`CHK(q[3], 1'b0)
		rdc(4'h0, 16'h0300);
		rdc(4'h3, 16'h0001);
		rdc(4'h7, 16'h000A);
		rdc(4'h8, 16'h0001);
		rdc(4'h9, 16'h0001);
		rdc(4'h4, 16'h0000);
		rdc(4'hF, 16'h0000);
		// good request 256 with wait 0
		wr(4'h6, 16'h0005);
		wr(4'h3, 16'h0000);
		wr(4'h5, 16'h0100);
		wait_tx(c);
		`CHK(c inside {[10:14]}, 1'b1)
		`CHK(mtx_req, {11'h100, 8'h05})
		rdc(4'h1, 16'h0004, 16'h0004);
		repeat (10) @(posedge clk);
		rdc(4'h1, 16'h0000, 16'h0007);
		scan;
		rdc(4'h1, 16'h0001, 16'h0003);
		rdc(4'h2, 16'h0020);
		// request 7 fails three times with two retries, then gives up
		wr(4'h0, 16'h0200);
		wr(4'h3, 16'h0003);
		code <= 5'h01;
		wr(4'h5, 16'h0007);
		wait_tx(c);
		`CHK(c inside {[30:34]}, 1'b1)
		wait_tx(c);
		`CHK(c inside {[33:45]}, 1'b1)
		wait_tx(c);
		`CHK(c inside {[33:45]}, 1'b1)
		wait_tx(c);
		`CHK(c, 200)
		scan;
		rdc(4'h1, 16'h0003, 16'h0007);
		rdc(4'h2, 16'h0701);
		rdc(4'h4, 16'h0501);
		wr(4'hA, 16'h0007);
		repeat (2) @(posedge clk);
		rdc(4'hB, 16'h0501);
		scan;
		rdc(4'h1, 16'h0000, 16'h0003);
		// shared word, 2041 refused, 2040 fails twice with one retry
		wr(4'h0, 16'h0101);
		code <= 5'h13;
		wr(4'h5, 16'h07F9);
		wait_tx(c);
		`CHK(c, 200)
		wr(4'h5, 16'h07F8);
		wait_tx(c);
		wait_tx(c);
		`CHK(c inside {[33:45]}, 1'b1)
		wait_tx(c);
		`CHK(c, 200)
		scan;
		rdc(4'h2, 16'hF8F3);
		wr(4'hA, 16'h0000);
		repeat (2) @(posedge clk);
		rdc(4'hB, 16'h0513);
		// silent station: the receive timeout ends request 9
		wr(4'h7, 16'h0001);
		silent <= 1'b1;
		wr(4'h5, 16'h0009);
		repeat (170) @(posedge clk);
		scan;
		rdc(4'h1, 16'h0003, 16'h0007);
		rdc(4'h2, 16'h0916);
		rdc(4'h4, 16'h0516);
		// ascii slave frame after an aborted one
		wr(4'h0, 16'h0002);
		send(":05");
		send(":01031234B6\r\n");
		repeat (20) @(posedge clk);
		`CHK(n_svc, 0)
		scan;
		repeat (3) @(posedge clk);
		`CHK(n_svc, 1)
		`CHK(acc, {8'h03, 16'h1234})
		`CHK(n_rsp, 0)
		repeat (20) @(posedge clk);
		`CHK(n_rsp, 1)
		// station 32 is beyond the legacy range and is not served
		wr(4'h8, 16'h0020);
		wr(4'h0, 16'h0006);
		send(":20031234B6\r\n");
		rdc(4'h1, 16'h0010, 16'h0010);
		scan;
		repeat (3) @(posedge clk);
		`CHK(n_svc, 1)
		conclude;
	end
endmodule
`default_nettype wire

// ===== mbrsu_top.sv
// Purpose: modbus master request sequencing, status words and slave intake
// Assumes: scan_end pulses once per program scan at end-of-scan housekeeping
// Notes: serial bytes arrive already deframed from a separate uart
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1 - error flag stands one whole scan
// RULE2 - error on retries exhausted or timeout
// RULE3 - drop failed request, go to next
// RULE4 - done flag and result word together
// RULE5 - launch bit clears itself on completion
// RULE6 - result word: request number, error code
// RULE7 - fixed set of five-bit error codes
// RULE8 - number split into low byte, bank
// RULE9 - delay each transmission by wait time
// RULE10 - log slave and code, cleared at power-up
// RULE11 - per-request status word, or shared one
// RULE12 - slave hands request out for access
// RULE13 - slave services only at scan end
// RULE14 - five selectable baud rates
// RULE15 - station range 1-247 or 1-31
// RULE16 - response delay 1 to 5000 ms
// RULE17 - 1.5 character gap ends character stream
// RULE18 - 3.5 character silence bounds frames
// RULE19 - result word valid during done scan
// RULE20 - wait 0 means 1, clamp 5000
// RULE21 - timeout discards partial frame
// RULE22 - colon starts or restarts ascii frame
module mbrsu_top #(
	parameter int unsigned CYC_PER_MS = mbrsu_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scan_end,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic mtx_valid,
	output mbrsu_pkg::mbrsu_req_t mtx_req,
	input wire logic mrsp_valid,
	input wire logic [4:0] mrsp_code,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic slv_svc,
	output mbrsu_pkg::mbrsu_acc_t slv_acc,
	output logic slv_resp_start
);
	typedef enum logic [1:0] {M_IDLE, M_WAIT, M_SEND, M_RESP} mbrsu_mst_t;

	// clamp a ms setting into 1..5000
	function automatic logic [12:0] clamp_ms(input logic [15:0] v);
		if (v == 16'h0000) return mbrsu_pkg::MS_MIN;
		if (v >= 16'(mbrsu_pkg::MS_MAX)) return mbrsu_pkg::MS_MAX;
		return v[12:0];
	endfunction

	// silence threshold in cycles for a number of half characters
	function automatic logic [19:0] gap_cyc(input logic [2:0] sel, input int unsigned halves);
		int unsigned baud;
		baud = mbrsu_pkg::BAUD0;
		case (sel)
			3'h1: baud = mbrsu_pkg::BAUD1;
			3'h2: baud = mbrsu_pkg::BAUD2;
			3'h3: baud = mbrsu_pkg::BAUD3;
			3'h4: baud = mbrsu_pkg::BAUD4;
			default: baud = mbrsu_pkg::BAUD0;
		endcase
		return 20'((mbrsu_pkg::CLK_HZ + baud - 1) / baud * mbrsu_pkg::CHAR_BITS * halves / 2);
	endfunction

	// register file state
	logic [15:0] ctrl_q, ctrl_d, wait_q, wait_d, rdly_q, rdly_d, rdata_d;
	logic [7:0] slvsel_q, slvsel_d, rxtmo_q, rxtmo_d, station_q, station_d;
	logic [10:0] erridx_q, erridx_d;
	logic [15:0] ram_q; // status word at erridx_q
	logic [3:0] retry_v; // retry setting held in range
	logic [2:0] baud_sel; // selected baud index
	// master state
	mbrsu_mst_t st_q, st_d;
	mbrsu_pkg::mbrsu_req_t req_q, req_d;
	logic [3:0] try_q, try_d; // failures so far
	logic busy_q, busy_d; // execute bit of the running request
	logic fin; // request finishes this cycle
	logic [4:0] fcode; // its code
	logic w_start, w_done, t_start, t_done;
	logic [12:0] tmo_ms; // receive timeout in ms
	// flags and words
	logic pend_done_q, pend_done_d, pend_err_q, pend_err_d;
	logic [15:0] pend_res_q, pend_res_d, result_q, result_d, log_q, log_d;
	logic done_flag_q, done_flag_d, err_flag_q, err_flag_d;
	logic [11:0] clr_q, clr_d; // power-up clear sweep
	logic clr_busy;
	logic ram_we;
	logic [10:0] ram_wa;
	logic [15:0] ram_wd;
	// slave intake state
	logic [19:0] sil_q, sil_d, t15, t35;
	logic infr_q, infr_d, skip_q, skip_d, rdy_q, rdy_d, half_q, half_d;
	logic [3:0] nib_q, nib_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] stn_q, stn_d;
	mbrsu_pkg::mbrsu_acc_t hdr_q, hdr_d;
	logic dly_q, dly_d, svc_d, rs_d, d_start, d_done;
	logic byte_ok; // a frame byte was decoded
	logic [7:0] byte_v;
	logic stn_ok; // station setting in range and matches

	assign retry_v = (ctrl_q[mbrsu_pkg::CTRL_RETRY_LSB +: 4] < mbrsu_pkg::RETRY_MIN)
		? mbrsu_pkg::RETRY_MIN : (ctrl_q[mbrsu_pkg::CTRL_RETRY_LSB +: 4] > mbrsu_pkg::RETRY_MAX)
		? mbrsu_pkg::RETRY_MAX : ctrl_q[mbrsu_pkg::CTRL_RETRY_LSB +: 4];
	assign baud_sel = ctrl_q[mbrsu_pkg::CTRL_BAUD_LSB +: 3]; // [RULE14]
	assign t15 = gap_cyc(baud_sel, mbrsu_pkg::GAP_CHAR_HALVES);
	assign t35 = gap_cyc(baud_sel, mbrsu_pkg::GAP_FRAME_HALVES);
	assign tmo_ms = (rxtmo_q == 8'h00) ? 13'(mbrsu_pkg::RXTMO_UNIT_MS)
		: 13'(rxtmo_q * mbrsu_pkg::RXTMO_UNIT_MS);
	assign clr_busy = !clr_q[11];
	assign mtx_valid = (st_q == M_SEND);
	assign mtx_req = req_q;

	// transmission wait, receive timeout and response delay timers
	mbrsu_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_wait (.clk(clk), .rst_b(rst_b),
		.start(w_start), .ms(clamp_ms(wait_q)), .done(w_done)); // [RULE20]
	mbrsu_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmo (.clk(clk), .rst_b(rst_b),
		.start(t_start), .ms(tmo_ms), .done(t_done));
	mbrsu_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_rdly (.clk(clk), .rst_b(rst_b),
		.start(d_start), .ms(clamp_ms(rdly_q)), .done(d_done)); // [RULE16]
	mbrsu_ram u_ram (.clk(clk), .we(ram_we), .waddr(ram_wa), .wdata(ram_wd),
		.raddr(erridx_q), .rdata(ram_q));

	// master request sequencing
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		try_d = try_q;
		busy_d = busy_q;
		fin = 1'b0;
		fcode = mbrsu_pkg::EC_OK;
		w_start = 1'b0;
		t_start = 1'b0;
		case (st_q)
			M_IDLE: begin
				// software sets the execute bit by writing a request number
				if (reg_wr && reg_addr == mbrsu_pkg::R_LAUNCH && !clr_busy
					&& reg_wdata[10:0] != 11'h000 && reg_wdata[10:0] <= mbrsu_pkg::REQ_MAX) begin
					req_d = '{num: reg_wdata[10:0], slave: slvsel_q};
					busy_d = 1'b1; // [RULE5]
					try_d = 4'h0;
					st_d = M_WAIT;
					w_start = 1'b1; // [RULE9]
				end
			end
			M_WAIT: begin
				if (w_done) begin
					st_d = M_SEND; // [RULE9]
				end
			end
			M_SEND: begin
				st_d = M_RESP;
				t_start = 1'b1;
			end
			M_RESP: begin
				if (mrsp_valid) begin
					if (mrsp_code == mbrsu_pkg::EC_OK) begin
						fin = 1'b1;
					end else if (try_q >= retry_v) begin
						// error only once failures outnumber the retry setting
						fin = 1'b1; // [RULE2]
						fcode = mrsp_code; // [RULE7]
					end else begin
						try_d = try_q + 4'h1;
						st_d = M_WAIT;
						w_start = 1'b1;
					end
				end else if (t_done) begin
					fin = 1'b1; // [RULE2]
					fcode = mbrsu_pkg::EC_TMO; // [RULE7]
				end
			end
			default: st_d = M_IDLE;
		endcase
		if (fin) begin
			st_d = M_IDLE; // [RULE3]
			busy_d = 1'b0; // [RULE5]
		end
	end

	// completion and error flags, result word, error records
	always_comb begin
		// a completion in a scan-end cycle waits for the next boundary
		pend_done_d = fin ? 1'b1 : (scan_end ? 1'b0 : pend_done_q);
		pend_err_d = (fin && fcode != mbrsu_pkg::EC_OK) ? 1'b1 : (scan_end ? 1'b0 : pend_err_q);
		pend_res_d = fin ? {req_q.num[7:0], req_q.num[10:8], fcode} : pend_res_q; // [RULE6] [RULE8]
		done_flag_d = scan_end ? pend_done_q : done_flag_q; // [RULE4]
		err_flag_d = scan_end ? pend_err_q : err_flag_q; // [RULE1]
		result_d = (scan_end && pend_done_q) ? pend_res_q : result_q; // [RULE4] [RULE19]
		log_d = (fin && fcode != mbrsu_pkg::EC_OK) ? {req_q.slave, 3'h0, fcode} : log_q; // [RULE10]
		clr_d = clr_busy ? clr_q + 12'h001 : clr_q;
		ram_we = clr_busy || (fin && fcode != mbrsu_pkg::EC_OK);
		ram_wa = clr_busy ? clr_q[10:0]
			: (ctrl_q[mbrsu_pkg::CTRL_SHARED] ? mbrsu_pkg::SHARED_IDX : req_q.num); // [RULE11]
		ram_wd = clr_busy ? 16'h0000 : {req_q.slave, 3'h0, fcode}; // [RULE10]
	end

	// slave frame intake and scan-end service
	always_comb begin
		sil_d = rx_valid ? 20'h00000 : (sil_q == 20'hFFFFF ? sil_q : sil_q + 20'h00001);
		infr_d = infr_q;
		skip_d = skip_q;
		rdy_d = rdy_q;
		half_d = half_q;
		nib_d = nib_q;
		cnt_d = cnt_q;
		stn_d = stn_q;
		hdr_d = hdr_q;
		dly_d = dly_q;
		svc_d = 1'b0;
		rs_d = 1'b0;
		d_start = 1'b0;
		byte_ok = 1'b0;
		byte_v = rx_byte;
		stn_ok = (station_q != 8'h00) && (stn_q == station_q) && (station_q
			<= (ctrl_q[mbrsu_pkg::CTRL_LEGACY] ? mbrsu_pkg::STN_MAX_OLD : mbrsu_pkg::STN_MAX_NEW));
		if (ctrl_q[mbrsu_pkg::CTRL_ASCII]) begin
			if (rx_valid && rx_byte == mbrsu_pkg::CH_COLON) begin
				infr_d = 1'b1; // [RULE22]
				cnt_d = 3'h0;
				half_d = 1'b0;
			end else if (rx_valid && infr_q && rx_byte == mbrsu_pkg::CH_LF) begin
				infr_d = 1'b0;
				rdy_d = 1'b1;
			end else if (rx_valid && infr_q && rx_byte != mbrsu_pkg::CH_CR) begin
				// two hex characters make one frame byte
				if (rx_byte >= 8'h30 && rx_byte <= 8'h39) begin
					byte_v = {nib_q, rx_byte[3:0]};
				end else if (rx_byte >= 8'h41 && rx_byte <= 8'h46) begin
					byte_v = {nib_q, rx_byte[3:0] + 4'h9};
				end else begin
					infr_d = 1'b0; // bad character drops the frame
				end
				if (infr_d) begin
					nib_d = byte_v[3:0];
					half_d = !half_q;
					byte_ok = half_q;
				end
			end
		end else begin
			if (infr_q && sil_q == t35) begin
				infr_d = 1'b0; // [RULE18]
				rdy_d = 1'b1;
			end
			if (skip_q && sil_q >= t35) begin
				skip_d = 1'b0;
			end
			if (rx_valid) begin
				if (infr_q && sil_q >= t15) begin
					infr_d = 1'b0; // [RULE17] [RULE21]
					skip_d = 1'b1;
				end else if (infr_q) begin
					byte_ok = 1'b1;
				end else if (!skip_q && !rdy_q) begin
					infr_d = 1'b1; // [RULE18]
					cnt_d = 3'h0;
					byte_ok = 1'b1;
				end
			end
		end
		// capture station, function and start address
		if (byte_ok) begin
			case (cnt_d)
				3'h0: stn_d = byte_v;
				3'h1: hdr_d.func = byte_v;
				3'h2: hdr_d.addr[15:8] = byte_v;
				3'h3: hdr_d.addr[7:0] = byte_v;
				default: ;
			endcase
			cnt_d = (cnt_d == 3'h4) ? cnt_d : cnt_d + 3'h1;
		end
		// a finished frame is served only in the end-of-scan phase
		if (rdy_q && scan_end) begin
			rdy_d = 1'b0; // [RULE13]
			if (stn_ok && cnt_q >= 3'h2 && !dly_q) begin
				svc_d = 1'b1; // [RULE12]
				dly_d = 1'b1;
				d_start = 1'b1; // [RULE16]
			end
		end
		if (dly_q && d_done) begin
			dly_d = 1'b0;
			rs_d = 1'b1;
		end
	end

	// register writes and read mux
	always_comb begin
		ctrl_d = ctrl_q;
		wait_d = wait_q;
		rdly_d = rdly_q;
		slvsel_d = slvsel_q;
		rxtmo_d = rxtmo_q;
		station_d = station_q;
		erridx_d = erridx_q;
		if (reg_wr) begin
			case (reg_addr)
				mbrsu_pkg::R_CTRL: ctrl_d = reg_wdata;
				mbrsu_pkg::R_WAIT: wait_d = reg_wdata; // [RULE9]
				mbrsu_pkg::R_SLVSEL: slvsel_d = reg_wdata[7:0];
				mbrsu_pkg::R_RXTMO: rxtmo_d = reg_wdata[7:0];
				mbrsu_pkg::R_STATION: station_d = reg_wdata[7:0]; // [RULE15]
				mbrsu_pkg::R_RDLY: rdly_d = reg_wdata;
				mbrsu_pkg::R_ERRIDX: erridx_d = reg_wdata[10:0];
				default: ;
			endcase
		end
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				mbrsu_pkg::R_CTRL: rdata_d = ctrl_q;
				mbrsu_pkg::R_STAT: rdata_d = {11'h000, rdy_q, clr_busy, busy_q, err_flag_q,
					done_flag_q};
				mbrsu_pkg::R_RESULT: rdata_d = result_q; // [RULE19]
				mbrsu_pkg::R_WAIT: rdata_d = wait_q;
				mbrsu_pkg::R_LOG: rdata_d = log_q;
				mbrsu_pkg::R_LAUNCH: rdata_d = {5'h00, req_q.num};
				mbrsu_pkg::R_SLVSEL: rdata_d = {8'h00, slvsel_q};
				mbrsu_pkg::R_RXTMO: rdata_d = {8'h00, rxtmo_q};
				mbrsu_pkg::R_STATION: rdata_d = {8'h00, station_q};
				mbrsu_pkg::R_RDLY: rdata_d = rdly_q;
				mbrsu_pkg::R_ERRIDX: rdata_d = {5'h00, erridx_q};
				mbrsu_pkg::R_ERRDAT: rdata_d = ram_q; // [RULE11]
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// all state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= M_IDLE;
			req_q <= '0;
			try_q <= 4'h0;
			busy_q <= 1'b0;
			pend_done_q <= 1'b0;
			pend_err_q <= 1'b0;
			pend_res_q <= 16'h0000;
			done_flag_q <= 1'b0;
			err_flag_q <= 1'b0;
			result_q <= 16'h0000;
			log_q <= 16'h0000; // [RULE10]
			clr_q <= 12'h000;
			sil_q <= 20'h00000;
			infr_q <= 1'b0;
			skip_q <= 1'b0;
			rdy_q <= 1'b0;
			half_q <= 1'b0;
			nib_q <= 4'h0;
			cnt_q <= 3'h0;
			stn_q <= 8'h00;
			hdr_q <= '0;
			dly_q <= 1'b0;
			slv_svc <= 1'b0;
			slv_acc <= '0;
			slv_resp_start <= 1'b0;
			ctrl_q <= mbrsu_pkg::CTRL_RST;
			wait_q <= mbrsu_pkg::WAIT_RST;
			rdly_q <= mbrsu_pkg::RDLY_RST;
			slvsel_q <= 8'h00;
			rxtmo_q <= mbrsu_pkg::RXTMO_RST;
			station_q <= mbrsu_pkg::STATION_RST;
			erridx_q <= 11'h000;
			reg_rdata <= 16'h0000;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			try_q <= try_d;
			busy_q <= busy_d;
			pend_done_q <= pend_done_d;
			pend_err_q <= pend_err_d;
			pend_res_q <= pend_res_d;
			done_flag_q <= done_flag_d;
			err_flag_q <= err_flag_d;
			result_q <= result_d;
			log_q <= log_d;
			clr_q <= clr_d;
			sil_q <= sil_d;
			infr_q <= infr_d;
			skip_q <= skip_d;
			rdy_q <= rdy_d;
			half_q <= half_d;
			nib_q <= nib_d;
			cnt_q <= cnt_d;
			stn_q <= stn_d;
			hdr_q <= hdr_d;
			dly_q <= dly_d;
			slv_svc <= svc_d;
			slv_acc <= svc_d ? hdr_q : slv_acc;
			slv_resp_start <= rs_d;
			ctrl_q <= ctrl_d;
			wait_q <= wait_d;
			rdly_q <= rdly_d;
			slvsel_q <= slvsel_d;
			rxtmo_q <= rxtmo_d;
			station_q <= station_d;
			erridx_q <= erridx_d;
			reg_rdata <= rdata_d;
		end
	end

	// checks on the guarded behaviour
	property p_err_scan;
		@(posedge clk) disable iff (!rst_b) $rose(err_flag_q) |-> $past(scan_end);
	endproperty
	a_err_scan: assert property (p_err_scan) else $error("error flag rose off scan end"); // [RULE1]
	property p_err_hold;
		@(posedge clk) disable iff (!rst_b) (err_flag_q && !scan_end) |=> err_flag_q;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag dropped mid scan"); // [RULE1]
	property p_err_done;
		@(posedge clk) disable iff (!rst_b) err_flag_q |-> done_flag_q;
	endproperty
	a_err_done: assert property (p_err_done) else $error("error without completion flag"); // [RULE4]
	property p_tmo;
		@(posedge clk) disable iff (!rst_b) (st_q == M_RESP && t_done && !mrsp_valid)
			|=> pend_err_q && pend_res_q[4:0] == mbrsu_pkg::EC_TMO && st_q == M_IDLE;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not reported"); // [RULE2]
	property p_pack;
		@(posedge clk) disable iff (!rst_b) fin |=> pend_res_q[15:8] == $past(req_q.num[7:0])
			&& pend_res_q[7:5] == $past(req_q.num[10:8]);
	endproperty
	a_pack: assert property (p_pack) else $error("result word packed wrong"); // [RULE8]
	property p_clear;
		@(posedge clk) disable iff (!rst_b) fin |=> !busy_q && st_q == M_IDLE;
	endproperty
	a_clear: assert property (p_clear) else $error("execute bit not cleared"); // [RULE5]
	property p_send;
		@(posedge clk) disable iff (!rst_b) $rose(mtx_valid) |-> $past(st_q) == M_WAIT && $past(w_done);
	endproperty
	a_send: assert property (p_send) else $error("sent without wait"); // [RULE9]
	property p_svc;
		@(posedge clk) disable iff (!rst_b) slv_svc |-> $past(scan_end) && !rdy_q;
	endproperty
	a_svc: assert property (p_svc) else $error("slave served mid scan"); // [RULE13]
	property p_colon;
		@(posedge clk) disable iff (!rst_b) (ctrl_q[mbrsu_pkg::CTRL_ASCII] && rx_valid
			&& rx_byte == mbrsu_pkg::CH_COLON && !reg_wr) |=> infr_q && cnt_q == 3'h0 && !half_q;
	endproperty
	a_colon: assert property (p_colon) else $error("colon did not restart frame"); // [RULE22]
	property p_log;
		@(posedge clk) disable iff (!rst_b) (fin && fcode != mbrsu_pkg::EC_OK)
			|=> log_q == {$past(req_q.slave), 3'h0, $past(fcode)};
	endproperty
	a_log: assert property (p_log) else $error("error log not written"); // [RULE10]
endmodule
`default_nettype wire
